/* File: src/tape_seq_regs.vh */
// constants for the tape function sequencer
`ifndef TAPE_SEQ_REGS_VH
`define TAPE_SEQ_REGS_VH

// ****************************************
// function codes
// ****************************************
`define FN_MOVE      3'h0
`define FN_SEARCH    3'h1
`define FN_RD_DATA   3'h2
`define FN_RD_ALL    3'h3
`define FN_WR_DATA   3'h4
`define FN_WR_ALL    3'h5
`define FN_WR_TIMING 3'h6
`define FN_UNUSED    3'h7

// ****************************************
// widths and sizes
// ****************************************
`define WORD_W      18
`define ADDR_W      15
`define BLOCK_WORDS 9'h100
`define FIFO_DEPTH  4
`define FIFO_AW     2
`define SYNC_N      7

// ****************************************
// timing, printed figures then cycles
// ****************************************
`define CLK_MHZ        20
`define WORD_US        200
`define RESP_US        200
`define RESP_TOL_PCT   30
`define SW_RD_US       400
`define SW_SRCH_US     1000
`define MOTION_MS      375
`define WORD_CYC       (`WORD_US * `CLK_MHZ)
`define WORD_LAST      12'hf9f  // last count of one word period
`define RESP_CYC       (`RESP_US * `CLK_MHZ * (100 + `RESP_TOL_PCT) / 100)
`define SW_RD_CYC      (`SW_RD_US * `CLK_MHZ)
`define SW_SRCH_CYC    (`SW_SRCH_US * `CLK_MHZ)
`define MOTION_CYC     (`MOTION_MS * 1000 * `CLK_MHZ)
`endif

/* File: src/word_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo
#(
    parameter WIDTH = 18,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire             mclk,
    input  wire             srst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    // storage, no reset needed on the array
    always @(posedge mclk)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data;
    end

    // pointers and count; flush drops everything held
    always @(posedge mclk)
    begin
        if (srst | flush)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            if (push & ~pop)
                count_ff <= count_ff + 1'b1;
            else if (pop & ~push)
                count_ff <= count_ff - 1'b1;
        end
    end

endmodule

/* File: src/tape_function_sequencer.v */
// function, counter, flag and error sequencing for a block tape control
`timescale 1ns/1ps
`include "tape_seq_regs.vh"
module tape_function_sequencer
#(
    parameter [22:0] MOTION_CYC  = `MOTION_CYC,
    parameter [22:0] SW_RD_CYC   = `SW_RD_CYC,
    parameter [22:0] SW_SRCH_CYC = `SW_SRCH_CYC,
    parameter [22:0] RESP_CYC    = `RESP_CYC
)
(
    input  wire                mclk,
    input  wire                srst,
    input  wire                go,
    input  wire                reverse,
    input  wire [2:0]          func_code,
    input  wire                continuous_mode,
    input  wire                ca_load,
    input  wire [`ADDR_W-1:0]  ca_load_val,
    input  wire                wc_load,
    input  wire [`WORD_W-1:0]  wc_load_val,
    input  wire                flag_clear,
    input  wire                err_clear,
    output reg                 tape_done_flag_ff,
    output reg                 select_error_ff,
    output reg                 end_of_tape_error_ff,
    output reg                 timing_error_ff,
    output reg                 mark_track_error_ff,
    output reg                 parity_error_ff,
    output reg                 wc_overflow_ff,
    output reg  [`ADDR_W-1:0]  current_address_ff,
    output reg  [`WORD_W-1:0]  word_count_ff,
    output wire                at_speed,
    output reg                 motor_on_ff,
    output reg                 motor_rev_ff,
    output wire                ch_req,
    output wire                ch_to_mem,
    input  wire                ch_ack,
    output wire [`ADDR_W-1:0]  ch_addr,
    output wire [`WORD_W-1:0]  ch_rdata,
    input  wire [`WORD_W-1:0]  ch_wdata,
    input  wire                block_mark_pin,
    input  wire                block_end_pin,
    input  wire                word_ready_pin,
    input  wire [`WORD_W-1:0]  tape_rdata_pin,
    input  wire                select_fault_pin,
    input  wire                end_zone_pin,
    input  wire                mark_fault_pin,
    input  wire                parity_fault_pin,
    output reg  [`WORD_W-1:0]  tape_wdata_ff,
    output reg                 tape_wstrobe_ff
);

    // ****************************************
    // motion states, one-hot
    // ****************************************
    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_ACCEL  = 5'h02;
    localparam [4:0] ST_SWITCH = 5'h04;
    localparam [4:0] ST_RUN    = 5'h08;
    localparam [4:0] ST_DECEL  = 5'h10;

    reg  [4:0]            state_ff;
    reg  [4:0]            nxt_state;
    reg  [22:0]           timer_ff;
    reg  [22:0]           nxt_timer;
    reg  [2:0]            func_ff;
    reg                   mode_ff;
    reg                   go_d_ff;
    reg  [11:0]           word_tmr_ff;
    reg  [8:0]            blk_cnt_ff;
    reg                   in_blk_ff;
    reg  [22:0]           resp_tmr_ff;
    reg  [`WORD_W-1:0]    rd_word_ff;
    reg                   rd_push_ff;

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [`SYNC_N-1:0]    pins_raw;
    reg  [`SYNC_N-1:0]    sync0_ff;
    reg  [`SYNC_N-1:0]    sync1_ff;
    reg  [`SYNC_N-1:0]    sync2_ff;
    reg  [`SYNC_N-1:0]    filt_ff;
    reg  [`SYNC_N-1:0]    filt_d_ff;
    wire [`SYNC_N-1:0]    rise;

    assign pins_raw = {parity_fault_pin, mark_fault_pin, end_zone_pin,
                       select_fault_pin, word_ready_pin, block_end_pin,
                       block_mark_pin};

    // three stages; a level counts only when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_N; gi = gi + 1)
        begin : g_sync
            always @(posedge mclk)
            begin
                if (srst)
                begin
                    sync0_ff[gi]  <= 1'b0;
                    sync1_ff[gi]  <= 1'b0;
                    sync2_ff[gi]  <= 1'b0;
                    filt_ff[gi]   <= 1'b0;
                    filt_d_ff[gi] <= 1'b0;
                end
                else
                begin
                    sync0_ff[gi]  <= pins_raw[gi];
                    sync1_ff[gi]  <= sync0_ff[gi];
                    sync2_ff[gi]  <= sync1_ff[gi];
                    if (sync1_ff[gi] == sync2_ff[gi])
                        filt_ff[gi] <= sync2_ff[gi];
                    filt_d_ff[gi] <= filt_ff[gi];
                end
            end
        end
    endgenerate

    assign rise = filt_ff & ~filt_d_ff;

    wire blk_mark_evt = rise[0];
    wire blk_end_evt  = rise[1];
    wire word_evt     = rise[2];
    wire sel_evt      = rise[3];
    wire eot_evt      = rise[4];
    wire mark_evt     = rise[5];
    wire par_evt      = rise[6];

    // ****************************************
    // function decode
    // ****************************************
    wire fn_move   = (func_ff == `FN_MOVE);
    wire fn_search = (func_ff == `FN_SEARCH);
    wire fn_rdata  = (func_ff == `FN_RD_DATA);
    wire fn_data   = fn_rdata | (func_ff == `FN_WR_DATA);
    wire fn_all    = (func_ff == `FN_RD_ALL) | (func_ff == `FN_WR_ALL) |
                     (func_ff == `FN_WR_TIMING);
    wire fn_write  = (func_ff == `FN_WR_DATA) | (func_ff == `FN_WR_ALL) |
                     (func_ff == `FN_WR_TIMING);
    wire fn_read   = fn_rdata | (func_ff == `FN_RD_ALL);
    wire fn_xfer   = fn_read | fn_write;                             // code 7 in none
    wire cm        = mode_ff;

    wire run       = state_ff[3];
    wire func_chg  = (func_code != func_ff) | (continuous_mode != mode_ff);
    wire new_func  = func_chg | (go & ~go_d_ff);
    wire to_data   = fn_search & ((func_code == `FN_RD_DATA) | (func_code == `FN_WR_DATA));
    wire to_search = fn_xfer & (func_code == `FN_SEARCH);

    assign at_speed = run;

    // ****************************************
    // data path through the fifo
    // ****************************************
    wire                fifo_in_valid;
    wire                fifo_in_ready;
    wire [`WORD_W-1:0]  fifo_in_data;
    wire                fifo_out_valid;
    wire                fifo_out_ready;
    wire [`WORD_W-1:0]  fifo_out_data;
    wire                word_tick;
    wire                tape_emit;
    wire                xfer;

    // channel side: reads drain the fifo, writes fill it
    assign ch_req    = run & fn_xfer & ~wc_overflow_ff &
                       (fn_write ? fifo_in_ready : fifo_out_valid);
    assign ch_to_mem = fn_read;
    assign ch_addr   = current_address_ff;
    assign ch_rdata  = fifo_out_data;
    assign xfer      = ch_req & ch_ack;

    // write cadence: one word per word period inside a block
    assign word_tick = (word_tmr_ff == `WORD_LAST);
    assign tape_emit = run & fn_write & in_blk_ff & word_tick &
                       fifo_out_valid & ~wc_overflow_ff;

    assign fifo_in_valid  = fn_write ? xfer : rd_push_ff;
    assign fifo_in_data   = fn_write ? ch_wdata : rd_word_ff;
    assign fifo_out_ready = fn_write ? tape_emit : xfer;

    word_fifo
    #(
        .WIDTH (`WORD_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    )
    u_fifo
    (
        .mclk      (mclk),
        .srst      (srst),
        .flush     (new_func),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ****************************************
    // counter events
    // ****************************************
    wire wc_inc  = run & ((fn_search & blk_mark_evt) | (fn_xfer & xfer));
    wire ca_inc  = run & fn_xfer & xfer;
    wire wc_wrap = wc_inc & (&word_count_ff);
    wire ovf_now = wc_overflow_ff | wc_wrap;

    // flag per function and mode; move and code 7 never set it
    wire set_flag = run & (
        (fn_search & blk_mark_evt & (~cm | wc_wrap)) |
        (fn_data & blk_end_evt & (~cm | ovf_now)) |
        (fn_all & xfer & (~cm | wc_wrap)));

    // timing faults: late channel, read overrun, write underrun
    wire rd_overrun = rd_push_ff & ~fifo_in_ready & ~wc_overflow_ff;
    wire wr_under   = run & fn_write & in_blk_ff & word_tick &
                      ~fifo_out_valid & ~wc_overflow_ff;
    wire resp_late  = ch_req & (resp_tmr_ff == RESP_CYC);
    wire tim_evt    = ~fn_move & (rd_overrun | wr_under | resp_late);

    // ****************************************
    // motion sequencer
    // ****************************************
    // a stop request always wins; turnaround re-accelerates
    always @*
    begin
        nxt_state = state_ff;
        nxt_timer = (timer_ff != 23'h0) ? timer_ff - 23'h1 : 23'h0;
        case (state_ff)
            ST_IDLE:
            begin
                if (go)
                begin
                    nxt_state = ST_ACCEL;
                    nxt_timer = MOTION_CYC;
                end
            end
            ST_ACCEL, ST_SWITCH:
            begin
                if (~go)
                begin
                    nxt_state = ST_DECEL;
                    nxt_timer = MOTION_CYC;
                end
                else if (timer_ff == 23'h0)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (~go)
                begin
                    nxt_state = ST_DECEL;
                    nxt_timer = MOTION_CYC;
                end
                else if (reverse != motor_rev_ff)
                begin
                    nxt_state = ST_ACCEL;
                    nxt_timer = MOTION_CYC;
                end
                else if (to_data)
                begin
                    nxt_state = ST_SWITCH;
                    nxt_timer = SW_RD_CYC;
                end
                else if (to_search)
                begin
                    nxt_state = ST_SWITCH;
                    nxt_timer = SW_SRCH_CYC;
                end
            end
            ST_DECEL:
            begin
                if (timer_ff == 23'h0)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_timer = 23'h0;
            end
        endcase
    end

    // state, motor and host-side latches
    always @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff     <= ST_IDLE;
            timer_ff     <= 23'h0;
            func_ff      <= `FN_MOVE;
            mode_ff      <= 1'b0;
            go_d_ff      <= 1'b0;
            motor_on_ff  <= 1'b0;
            motor_rev_ff <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            timer_ff    <= nxt_timer;
            func_ff     <= func_code;
            mode_ff     <= continuous_mode;
            go_d_ff     <= go;
            motor_on_ff <= ~nxt_state[0];
            // direction only flips when a (re)start begins
            if (nxt_state[1] & ~state_ff[1])
                motor_rev_ff <= reverse;
        end
    end

    // ****************************************
    // tape-side word handling
    // ****************************************
    // read data is stable well before the synchronised strobe edge
    always @(posedge mclk)
    begin
        if (srst)
        begin
            rd_word_ff      <= {`WORD_W{1'b0}};
            rd_push_ff      <= 1'b0;
            word_tmr_ff     <= 12'h0;
            blk_cnt_ff      <= 9'h0;
            in_blk_ff       <= 1'b0;
            tape_wdata_ff   <= {`WORD_W{1'b0}};
            tape_wstrobe_ff <= 1'b0;
            resp_tmr_ff     <= 23'h0;
        end
        else
        begin
            rd_push_ff <= run & fn_read & in_blk_ff & word_evt &
                          ~wc_overflow_ff;
            if (word_evt)
                rd_word_ff <= tape_rdata_pin;
            word_tmr_ff <= word_tick ? 12'h0 : word_tmr_ff + 12'h1;
            tape_wstrobe_ff <= tape_emit;
            if (tape_emit)
                tape_wdata_ff <= fifo_out_data;
            // block window closes at its end or after a full block
            if (blk_mark_evt)
            begin
                in_blk_ff  <= 1'b1;
                blk_cnt_ff <= 9'h0;
            end
            else if (blk_end_evt | (blk_cnt_ff == `BLOCK_WORDS))
                in_blk_ff <= 1'b0;
            else if (tape_emit | (word_evt & fn_read))
                blk_cnt_ff <= blk_cnt_ff + 9'h1;
            // channel wait timer, saturates at the limit
            if (~ch_req | ch_ack)
                resp_tmr_ff <= 23'h0;
            else if (resp_tmr_ff != RESP_CYC)
                resp_tmr_ff <= resp_tmr_ff + 23'h1;
        end
    end

    // ****************************************
    // address and word counters
    // ****************************************
    // a software load outranks a count in the same cycle
    always @(posedge mclk)
    begin
        if (srst)
        begin
            current_address_ff <= {`ADDR_W{1'b0}};
            word_count_ff      <= {`WORD_W{1'b0}};
            wc_overflow_ff     <= 1'b0;
        end
        else
        begin
            if (ca_load)
                current_address_ff <= ca_load_val;
            else if (ca_inc)
                current_address_ff <= current_address_ff + 1'b1;
            // budget arrives as a negative count
            if (wc_load)
                word_count_ff <= wc_load_val;
            else if (wc_inc)
                word_count_ff <= word_count_ff + 1'b1;
            if (new_func)
                wc_overflow_ff <= 1'b0;
            else if (wc_wrap)
                wc_overflow_ff <= 1'b1;
        end
    end

    // ****************************************
    // done flag and error flags
    // ****************************************
    // sticky; a new event in the clear cycle still lands
    always @(posedge mclk)
    begin
        if (srst)
        begin
            tape_done_flag_ff    <= 1'b0;
            select_error_ff      <= 1'b0;
            end_of_tape_error_ff <= 1'b0;
            timing_error_ff      <= 1'b0;
            mark_track_error_ff  <= 1'b0;
            parity_error_ff      <= 1'b0;
        end
        else
        begin
            tape_done_flag_ff <= set_flag | (tape_done_flag_ff & ~flag_clear);
            select_error_ff <= (motor_on_ff & sel_evt) |
                               (select_error_ff & ~err_clear);
            end_of_tape_error_ff <= (run & eot_evt & (func_ff != `FN_WR_TIMING)) |
                                    (end_of_tape_error_ff & ~err_clear);
            timing_error_ff <= (run & tim_evt) |
                               (timing_error_ff & ~err_clear);
            mark_track_error_ff <= (run & mark_evt & (fn_search | fn_data |
                                    (func_ff == `FN_RD_ALL) | (func_ff == `FN_WR_ALL))) |
                                   (mark_track_error_ff & ~err_clear);
            parity_error_ff <= (run & par_evt & fn_rdata) |
                               (parity_error_ff & ~err_clear);
        end
    end

endmodule

/* File: dv/tape_seq_props.sv */
// concurrent checks on the tape function sequencer ports
`timescale 1ns/1ps
`include "tape_seq_regs.vh"
module tape_seq_props
(
    input wire        mclk,
    input wire        srst,
    input wire        go,
    input wire [2:0]  func_code,
    input wire        continuous_mode,
    input wire        ca_load,
    input wire        wc_load,
    input wire        ch_req,
    input wire        ch_ack,
    input wire        tape_done_flag_ff,
    input wire        timing_error_ff,
    input wire        parity_error_ff,
    input wire        wc_overflow_ff,
    input wire [14:0] current_address_ff,
    input wire [17:0] word_count_ff
);
    // ****************************************
    // helper: cycles since the last new function
    // ****************************************
    reg [2:0] fc_q;
    reg       cm_q;
    reg       go_q;
    reg [1:0] age;
    wire      idle_fn = (func_code == `FN_MOVE) || (func_code == `FN_UNUSED);
    // saturates so a long run never wraps back to a fresh age
    always @(posedge mclk)
    begin
        fc_q <= func_code;
        cm_q <= continuous_mode;
        go_q <= go;
        age  <= (func_code != fc_q || continuous_mode != cm_q || (go && !go_q)) ? 2'd0 : ((age == 2'd3) ? age : age + 2'd1);
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    AST_IDLE_NO_FLAG: assert property (idle_fn && $past(func_code) == func_code |-> !$rose(tape_done_flag_ff))
        else $error("done flag rose in move or unused function");
    AST_IDLE_WC_HOLD: assert property (idle_fn && $past(func_code) == func_code && !$past(wc_load) && !$past(srst)
        |-> $stable(word_count_ff)) else $error("word count moved in move function");
    AST_CA_HOLD: assert property ((idle_fn || func_code == `FN_SEARCH) && $past(func_code) == func_code
        && !$past(ca_load) && !$past(srst) |-> $stable(current_address_ff)) else $error("address moved");
    AST_ACK_STEPS: assert property (ch_req && ch_ack && !ca_load && !wc_load |=>
        current_address_ff == $past(current_address_ff) + 15'h1 && word_count_ff == $past(word_count_ff) + 18'h1)
        else $error("counters did not step on a transfer");
    AST_NO_REQ_AFTER_OVF: assert property (wc_overflow_ff |-> !ch_req)
        else $error("request after overflow");
    AST_OVF_AT_WRAP: assert property ($rose(wc_overflow_ff) |-> word_count_ff == 18'h0
        && $past(word_count_ff) == 18'h3ffff) else $error("overflow without wrap");
    AST_OVF_HELD: assert property ($fell(wc_overflow_ff) && !$past(srst) |-> age != 2'd3)
        else $error("overflow dropped without new function");
    AST_PARITY_READ: assert property ($rose(parity_error_ff) |-> $past(func_code, 2) == `FN_RD_DATA)
        else $error("parity error outside read data");
    AST_MOVE_NO_TIMING: assert property (idle_fn && $past(func_code) == func_code |-> !$rose(timing_error_ff))
        else $error("timing error in move");
endmodule
bind tape_function_sequencer tape_seq_props u_props (.mclk(mclk), .srst(srst), .go(go), .func_code(func_code),
    .continuous_mode(continuous_mode), .ca_load(ca_load), .wc_load(wc_load), .ch_req(ch_req), .ch_ack(ch_ack),
    .tape_done_flag_ff(tape_done_flag_ff), .timing_error_ff(timing_error_ff), .parity_error_ff(parity_error_ff),
    .wc_overflow_ff(wc_overflow_ff), .current_address_ff(current_address_ff), .word_count_ff(word_count_ff));

/* File: dv/tape_model.sv */
// tape transport model: block mark, words, block end while at speed
`timescale 1ns/1ps
module tape_model
#(
    parameter NWORDS = 3
)
(
    input  wire        mclk,
    input  wire        run,
    output reg         block_mark_pin,
    output reg         block_end_pin,
    output reg         word_ready_pin,
    output reg  [17:0] tape_rdata_pin
);
    integer i;
    // short blocks keep the run brief; data settles before each strobe
    initial
    begin
        block_mark_pin = 1'b0;
        block_end_pin = 1'b0;
        word_ready_pin = 1'b0;
        tape_rdata_pin = 18'h15555;
        forever
        begin
            @(negedge mclk);
            if (run)
            begin
                block_mark_pin = 1'b1;
                repeat (8) @(negedge mclk);
                block_mark_pin = 1'b0;
                for (i = 0; i < NWORDS; i = i + 1)
                begin
                    tape_rdata_pin = {14'h0a50, i[3:0]};
                    repeat (4) @(negedge mclk);
                    word_ready_pin = 1'b1;
                    repeat (8) @(negedge mclk);
                    word_ready_pin = 1'b0;
                    tape_rdata_pin = ~tape_rdata_pin; // stale word never lingers
                    repeat (4) @(negedge mclk);
                end
                block_end_pin = 1'b1;
                repeat (8) @(negedge mclk);
                block_end_pin = 1'b0;
            end
        end
    end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the tape function sequencer
`timescale 1ns/1ps
`include "tape_seq_regs.vh"
module testbench;
    reg         mclk, srst, go, cm, ca_load, wc_load, flag_clear, err_clear, par, ch_ack;
    reg  [2:0]  fc;
    reg  [14:0] ca_v;
    reg  [17:0] wc_v;
    wire        flag, perr, terr, serr, eerr, merr, ovf, at_speed, ch_req, bm, be, wr;
    wire [14:0] ca;
    wire [17:0] wc, td;
    integer     mismatches, num_checks, k, n, cycles;
    tape_function_sequencer #(.MOTION_CYC(23'd50), .SW_RD_CYC(23'd10), .SW_SRCH_CYC(23'd12), .RESP_CYC(23'd20)) uut (
        .mclk(mclk), .srst(srst), .go(go), .reverse(cm), .func_code(fc), .continuous_mode(cm),
        .ca_load(ca_load), .ca_load_val(ca_v), .wc_load(wc_load), .wc_load_val(wc_v), .flag_clear(flag_clear),
        .err_clear(err_clear), .tape_done_flag_ff(flag), .select_error_ff(serr), .end_of_tape_error_ff(eerr),
        .timing_error_ff(terr), .mark_track_error_ff(merr), .parity_error_ff(perr), .wc_overflow_ff(ovf),
        .current_address_ff(ca), .word_count_ff(wc), .at_speed(at_speed), .motor_on_ff(), .motor_rev_ff(),
        .ch_req(ch_req), .ch_to_mem(), .ch_ack(ch_ack), .ch_addr(), .ch_rdata(), .ch_wdata(wc_v),
        .block_mark_pin(bm), .block_end_pin(be), .word_ready_pin(wr), .tape_rdata_pin(td), .select_fault_pin(par),
        .end_zone_pin(par), .mark_fault_pin(par), .parity_fault_pin(par), .tape_wdata_ff(), .tape_wstrobe_ff());
    tape_model u_tape (.mclk(mclk), .run(at_speed), .block_mark_pin(bm), .block_end_pin(be), .word_ready_pin(wr),
        .tape_rdata_pin(td));
    // ****************************************
    // clock, prompt channel, hang guard
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // channel answers on the next falling edge and holds until sampled
    always @(negedge mclk) ch_ack <= ch_req;
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 10000)
        begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    task chk(input string nm, input [17:0] e, input [17:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("unexpected %0s: expected %h, seen %h", nm, e, g);
        end
    end
    endtask
    task ticks(input integer t);
        repeat (t) @(negedge mclk);
    endtask
    // stop, load counters, clear a stale flag, start a new function
    task restart(input [2:0] f, input m, input [14:0] a, input [17:0] w);
    begin
        go = 1'b0;
        ticks(60);
        fc = f;
        cm = m;
        ca_v = a;
        wc_v = w;
        ca_load = 1'b1;
        wc_load = 1'b1;
        flag_clear = 1'b1;
        ticks(1);
        ca_load = 1'b0;
        wc_load = 1'b0;
        flag_clear = 1'b0;
        go = 1'b1;
        for (k = 0; k < 100 && at_speed !== 1'b1; k = k + 1) ticks(1);
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {srst, go, cm, ca_load, wc_load, flag_clear, err_clear, par} = 8'h80;
        fc = 3'h0;
        ca_v = 15'h0;
        wc_v = 18'h0;
        {mismatches, num_checks, cycles} = 0;
        ticks(8);
        srst = 1'b0;
        chk("flag", 18'h0, {17'h0, flag});
        restart(`FN_SEARCH, 1'b0, 15'h0100, 18'h0);
        for (n = 1; n < 3; n = n + 1)
        begin
            flag_clear = 1'b0;
            for (k = 0; k < 300 && flag !== 1'b1; k = k + 1) ticks(1);
            ticks(2);
            chk("wc", n, wc);
            chk("ca", 18'h0100, {3'h0, ca});
            flag_clear = 1'b1;
            ticks(1);
        end
        flag_clear = 1'b0;
        $display("test search done");
        restart(`FN_RD_ALL, 1'b1, 15'h0200, 18'h3fffd);
        for (k = 0; k < 300 && wc !== 18'h3ffff; k = k + 1) ticks(1);
        chk("flag", 18'h0, {17'h0, flag});
        for (k = 0; k < 300 && ovf !== 1'b1; k = k + 1) ticks(1);
        ticks(2);
        chk("flag", 18'h1, {17'h0, flag});
        chk("wc", 18'h0, wc);
        ticks(150);
        chk("ca", 18'h0203, {3'h0, ca});
        $display("test read all done");
        restart(`FN_RD_DATA, 1'b0, 15'h0, 18'h0);
        par = 1'b1;
        ticks(10);
        par = 1'b0;
        for (k = 0; k < 300 && flag !== 1'b1; k = k + 1) ticks(1);
        ticks(2);
        chk("ca", 18'h3, {3'h0, ca});
        chk("wc", 18'h3, wc);
        chk("errs", 18'h0f, {13'h0, terr, serr, eerr, merr, perr});
        err_clear = 1'b1;
        ticks(1);
        err_clear = 1'b0;
        ticks(2);
        chk("errs", 18'h00, {13'h0, terr, serr, eerr, merr, perr});
        $display("test read data done");
        restart(`FN_WR_ALL, 1'b0, 15'h0010, 18'h3ffff);
        for (k = 0; k < 300 && ovf !== 1'b1; k = k + 1) ticks(1);
        ticks(20);
        chk("ca", 18'h0011, {3'h0, ca});
        chk("flag", 18'h1, {17'h0, flag});
        $display("test write all done");
        for (n = 0; n < 2; n = n + 1)
        begin
            restart(n ? `FN_UNUSED : `FN_MOVE, 1'b0, 15'h7fff, 18'h3ffff);
            par = 1'b1;
            ticks(300);
            chk("flag", 18'h0, {17'h0, flag});
            chk("errs", 18'h0c, {13'h0, terr, serr, eerr, merr, perr});
            chk("wc", 18'h3ffff, wc);
            chk("ca", 18'h7fff, {3'h0, ca});
        end
        $display("test move and unused done");
        end_of_test;
    end
endmodule
